/* inc/iap_flash_map.svh */
// Register offsets, field positions, command codes and timing counts of the flash sequencer
// How it works
// [RULE1] Operations start only in programming mode, on a command register write.
// [RULE2] Commands aimed at a security-locked block are refused.
// [RULE3] Code 01H with data 55H erases both flash blocks entirely.
// [RULE4] Whole-array erase only with external access pin low and not lock level 4.
// [RULE5] Whole-array erase ignores locks and clears security and re-map bits.
// [RULE6] Code 0DH, data 55H erases a block; high bit 7=0 block 0, nibble EH block 1.
// [RULE7] Code 0BH erases one 128-byte sector at the high and low address.
// [RULE8] Code 0EH programs the data register byte at the high and low address.
// [RULE9] Code 0CH reads the addressed byte back fast, with no completion interrupt.
// [RULE10] For read-back, high bits 7:5=111b select block 1, bit 7=0 block 0.
// [RULE11] Software waits for the previous operation to finish before a read-back.
// [RULE12] Software programs only erased bytes, erasing them first when needed.
// [RULE13] Software never writes the block it is fetching code from.
// [RULE14] Codes 0FH, 03H, 05H with AAH program security bits 1, 2, 3 respectively.
// [RULE15] Security bits move only to programmed; only whole-array erase clears them.
// [RULE16] Code 09H, AAH, high 5AH programs boot bit 0; bank select follows after reset.
// [RULE17] Code 09H, AAH, high AAH programs boot bit 1; config bit 1 follows after reset.
// [RULE18] Code 08H, AAH, high 55H switches the core from 12 to 6 clocks per cycle.
// [RULE19] Status bit 2 is busy: 1 while an operation runs, 0 when ready.
// [RULE20] Code-space reads aimed at a busy block fail.
// [RULE21] Command bit 7 set routes completion onto interrupt one, pin ignored meanwhile.
// [RULE22] Software enables interrupt one, global enable and edge trigger to receive it.
// [RULE23] Code running in one block always targets the other block.
// [RULE24] Command writes are ignored while busy.
// [RULE25] A low programming-disable pin at reset release disables commands until reset.
`ifndef IAP_FLASH_MAP_SVH
`define IAP_FLASH_MAP_SVH

// Register byte addresses
`define OFS_CMD 8'h00
`define OFS_STATUS 8'h04
`define OFS_ADDR_LO 8'h08
`define OFS_ADDR_HI 8'h0c
`define OFS_DATA 8'h10
`define OFS_CONFIG 8'h14
`define OFS_NVBITS 8'h18

// Field positions
`define CMD_IRQ_BIT 7
`define CFG_IAP_EN_BIT 6
`define AH_TOP_BIT 7

// Command codes in command bits 6:0
`define CODE_CHIP_ERASE 7'h01
`define CODE_BLOCK_ERASE 7'h0d
`define CODE_SECTOR_ERASE 7'h0b
`define CODE_BYTE_PROG 7'h0e
`define CODE_BYTE_VERIFY 7'h0c
`define CODE_PROG_SB1 7'h0f
`define CODE_PROG_SB2 7'h03
`define CODE_PROG_SB3 7'h05
`define CODE_PROG_SC 7'h09
`define CODE_CLK_DOUBLE 7'h08

// Key values in data and address-high
`define KEY_ERASE 8'h55
`define KEY_PROG 8'haa
`define AH_SC0 8'h5a
`define AH_SC1 8'haa
`define AH_CLK_DOUBLE 8'h55
`define AH_BLK1_NIBBLE 4'he
`define AH_BLK1_TOP3 3'h7

// Reset values and start-up timing
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000
`define INIT_LAST 2'h2 // Pin synchroniser filled by then
`define INIT_DONE 2'h3

`endif

/* inc/iap_flash_pkg.sv */
// Types shared by the flash command sequencer
`default_nettype none
package iap_flash_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_VERIFY = 3'h4
  } seq_state_e;

  // Operations handed to the flash array
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_CHIP_ERASE = 4'h1,
    OP_BLOCK_ERASE = 4'h2,
    OP_SECTOR_ERASE = 4'h3,
    OP_BYTE_PROG = 4'h4,
    OP_BYTE_VERIFY = 4'h5,
    OP_PROG_SB1 = 4'h6,
    OP_PROG_SB2 = 4'h7,
    OP_PROG_SB3 = 4'h8,
    OP_PROG_SC0 = 4'h9,
    OP_PROG_SC1 = 4'ha,
    OP_CLK_DOUBLE = 4'hb
  } flash_op_e;

  // Where the core currently fetches code from
  typedef enum logic [1:0] {
    SRC_BLOCK0 = 2'h0,
    SRC_BLOCK1 = 2'h1,
    SRC_EXTERNAL = 2'h2
  } fetch_src_e;

  // Request to the flash array macro
  typedef struct packed {
    logic valid;
    flash_op_e op;
    logic [1:0] block_mask;
    logic [15:0] addr;
    logic [7:0] wdata;
  } flash_req_s;

  // Whole state of the sequencer
  typedef struct packed {
    seq_state_e st;
    logic [7:0] cmd;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] data;
    logic iap_en;
    logic [2:0] sec;
    logic [1:0] sc;
    logic boot_bank_select;
    logic cfg1;
    logic clk_dbl;
    logic reject;
    logic iap_dis;
    logic [1:0] init_cnt;
    logic [1:0] ea_sync;
    logic [1:0] dis_sync;
    logic [1:0] irq_sync;
    logic irq_out;
    logic ack;
    logic [31:0] rdata;
    flash_op_e op;
    logic [1:0] blk;
  } state_s;

endpackage : iap_flash_pkg
`default_nettype wire

/* logic/iap_flash_command_sequencer.sv */
// Flash command sequencer with Avalon-MM mailbox registers
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`include "iap_flash_map.svh"
`default_nettype none
`timescale 1ns/10ps
module iap_flash_command_sequencer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Avalon-MM register slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Device pins, asynchronous
  input wire logic external_access_pin_i,
  input wire logic programming_disable_pin_i,
  input wire logic ext_irq_one_pin_i,
  // Core side
  input wire iap_flash_pkg::fetch_src_e fetch_src_i,
  input wire logic code_rd_req_i,
  input wire logic [1:0] code_rd_block_i,
  output logic code_rd_fail_o,
  output logic ext_irq_one_o,
  output logic clk_double_o,
  output logic boot_bank_select_o,
  // Non-volatile bits as stored in the array
  input wire logic [2:0] nvm_security_i,
  input wire logic [1:0] nvm_boot_cfg_i,
  // Flash array macro
  output iap_flash_pkg::flash_req_s flash_req_o,
  input wire logic flash_done_i,
  input wire logic [7:0] flash_rdata_i
);

  iap_flash_pkg::state_s s_q;
  iap_flash_pkg::state_s s_d;

  // Command decode from command, data and address-high
  function automatic iap_flash_pkg::flash_op_e decode_op(input logic [6:0] code,
                                                         input logic [7:0] dat,
                                                         input logic [7:0] ah);
    iap_flash_pkg::flash_op_e op;
    op = iap_flash_pkg::OP_NONE;
    case (code)
      `CODE_CHIP_ERASE: begin
        if (dat == `KEY_ERASE) op = iap_flash_pkg::OP_CHIP_ERASE; // RULE3
      end
      `CODE_BLOCK_ERASE: begin
        if (dat == `KEY_ERASE) op = iap_flash_pkg::OP_BLOCK_ERASE; // RULE6
      end
      `CODE_SECTOR_ERASE: op = iap_flash_pkg::OP_SECTOR_ERASE; // RULE7
      `CODE_BYTE_PROG: op = iap_flash_pkg::OP_BYTE_PROG; // RULE8
      `CODE_BYTE_VERIFY: op = iap_flash_pkg::OP_BYTE_VERIFY; // RULE9
      `CODE_PROG_SB1: begin
        if (dat == `KEY_PROG) op = iap_flash_pkg::OP_PROG_SB1; // RULE14
      end
      `CODE_PROG_SB2: begin
        if (dat == `KEY_PROG) op = iap_flash_pkg::OP_PROG_SB2; // RULE14
      end
      `CODE_PROG_SB3: begin
        if (dat == `KEY_PROG) op = iap_flash_pkg::OP_PROG_SB3; // RULE14
      end
      `CODE_PROG_SC: begin
        if (dat == `KEY_PROG && ah == `AH_SC0) op = iap_flash_pkg::OP_PROG_SC0; // RULE16
        if (dat == `KEY_PROG && ah == `AH_SC1) op = iap_flash_pkg::OP_PROG_SC1; // RULE17
      end
      `CODE_CLK_DOUBLE: begin
        if (dat == `KEY_PROG && ah == `AH_CLK_DOUBLE) op = iap_flash_pkg::OP_CLK_DOUBLE; // RULE18
      end
      default: op = iap_flash_pkg::OP_NONE;
    endcase
    return op;
  endfunction : decode_op

  // Target block mask: bit 0 block 0, bit 1 block 1, zero when no block matches
  function automatic logic [1:0] target_mask(input iap_flash_pkg::fetch_src_e src,
                                             input logic [7:0] ah,
                                             input logic nibble_rule);
    logic [1:0] m;
    m = 2'h0;
    if (src == iap_flash_pkg::SRC_BLOCK0) begin
      m = 2'h2; // RULE23
    end else if (src == iap_flash_pkg::SRC_BLOCK1) begin
      m = 2'h1; // RULE23
    end else if (!ah[`AH_TOP_BIT]) begin
      m = 2'h1; // RULE6 RULE10
    end else if (nibble_rule && ah[7:4] == `AH_BLK1_NIBBLE) begin
      m = 2'h2; // RULE6
    end else if (!nibble_rule && ah[7:5] == `AH_BLK1_TOP3) begin
      m = 2'h2; // RULE10
    end
    return m;
  endfunction : target_mask

  // Register write strobe taken when waitrequest is low, read strobe in the wait cycle
  logic wr_go;
  logic rd_go;
  logic busy;
  logic iap_active;
  iap_flash_pkg::flash_op_e new_op;
  logic [1:0] new_mask;
  logic locked;
  logic accept;

  assign wr_go = avs_write_i && s_q.ack && avs_byteenable_i[0];
  assign rd_go = avs_read_i && !s_q.ack;
  assign busy = (s_q.st != iap_flash_pkg::ST_IDLE); // RULE19
  assign iap_active = s_q.iap_en && !s_q.iap_dis && (s_q.init_cnt == `INIT_DONE);

  // Decode of the byte now being written to the command register
  always_comb begin
    new_op = decode_op(avs_writedata_i[6:0], s_q.data, s_q.addr_hi);
    new_mask = target_mask(fetch_src_i, s_q.addr_hi,
                           new_op == iap_flash_pkg::OP_BLOCK_ERASE);
    locked = |(new_mask & {2{|s_q.sec}}); // RULE2
    accept = 1'b0;
    case (new_op)
      iap_flash_pkg::OP_NONE: accept = 1'b0;
      iap_flash_pkg::OP_CHIP_ERASE: begin
        new_mask = 2'h3;
        accept = !s_q.ea_sync[1] && !(&s_q.sec); // RULE4 RULE5
      end
      iap_flash_pkg::OP_BLOCK_ERASE, iap_flash_pkg::OP_SECTOR_ERASE,
      iap_flash_pkg::OP_BYTE_PROG, iap_flash_pkg::OP_BYTE_VERIFY: begin
        accept = (new_mask != 2'h0) && !locked; // RULE2
      end
      default: begin
        new_mask = 2'h0;
        accept = 1'b1;
      end
    endcase
  end

  // Next state of the whole sequencer
  always_comb begin
    s_d = s_q;
    s_d.ack = (avs_read_i || avs_write_i) && !s_q.ack;
    s_d.ea_sync = {s_q.ea_sync[0], external_access_pin_i};
    s_d.dis_sync = {s_q.dis_sync[0], programming_disable_pin_i};
    s_d.irq_sync = {s_q.irq_sync[0], ext_irq_one_pin_i};
    s_d.irq_out = s_q.irq_sync[1];
    // Start-up capture of stored bits and the disable pin
    if (s_q.init_cnt != `INIT_DONE) begin
      s_d.init_cnt = s_q.init_cnt + 2'h1;
      if (s_q.init_cnt == `INIT_LAST) begin
        s_d.sec = nvm_security_i;
        s_d.sc = nvm_boot_cfg_i;
        s_d.boot_bank_select = nvm_boot_cfg_i[0];
        s_d.cfg1 = nvm_boot_cfg_i[1];
        s_d.iap_dis = !s_q.dis_sync[1]; // RULE25
      end
    end
    // Plain register writes
    if (wr_go) begin
      case (avs_address_i)
        `OFS_ADDR_LO: s_d.addr_lo = avs_writedata_i[7:0];
        `OFS_ADDR_HI: s_d.addr_hi = avs_writedata_i[7:0];
        `OFS_DATA: s_d.data = avs_writedata_i[7:0];
        `OFS_CONFIG: s_d.iap_en = avs_writedata_i[`CFG_IAP_EN_BIT];
        `OFS_CMD: begin
          if (!busy) begin // RULE24
            s_d.cmd = avs_writedata_i[7:0];
            s_d.op = new_op;
            s_d.blk = new_mask;
            s_d.reject = !(iap_active && accept); // RULE1 RULE2
            if (iap_active && accept) begin // RULE1
              s_d.st = (new_op == iap_flash_pkg::OP_BYTE_VERIFY) ?
                       iap_flash_pkg::ST_VERIFY : iap_flash_pkg::ST_RUN;
            end
          end
        end
        default: s_d.addr_lo = s_q.addr_lo;
      endcase
    end
    // Operation progress
    case (s_q.st)
      iap_flash_pkg::ST_IDLE: s_d.st = s_d.st;
      iap_flash_pkg::ST_RUN: begin
        if (flash_done_i) begin
          s_d.st = iap_flash_pkg::ST_IDLE; // RULE19
          case (s_q.op)
            iap_flash_pkg::OP_CHIP_ERASE: begin
              s_d.sec = 3'h0; // RULE5
              s_d.sc = 2'h0; // RULE5
            end
            iap_flash_pkg::OP_PROG_SB1: s_d.sec[0] = 1'b1; // RULE14 RULE15
            iap_flash_pkg::OP_PROG_SB2: s_d.sec[1] = 1'b1; // RULE14 RULE15
            iap_flash_pkg::OP_PROG_SB3: s_d.sec[2] = 1'b1; // RULE14 RULE15
            iap_flash_pkg::OP_PROG_SC0: s_d.sc[0] = 1'b1; // RULE16
            iap_flash_pkg::OP_PROG_SC1: s_d.sc[1] = 1'b1; // RULE17
            iap_flash_pkg::OP_CLK_DOUBLE: s_d.clk_dbl = 1'b1; // RULE18
            default: s_d.sc = s_d.sc;
          endcase
        end
      end
      iap_flash_pkg::ST_VERIFY: begin
        s_d.st = iap_flash_pkg::ST_IDLE;
        s_d.data = flash_rdata_i; // RULE9
      end
      default: s_d.st = iap_flash_pkg::ST_IDLE;
    endcase
    // Interrupt one routing while programming mode is on
    if (s_q.iap_en && s_q.cmd[`CMD_IRQ_BIT]) begin
      s_d.irq_out = (s_q.st == iap_flash_pkg::ST_RUN) && flash_done_i; // RULE21
    end
    // Read data latched in the wait cycle
    if (rd_go) begin
      case (avs_address_i)
        `OFS_CMD: s_d.rdata = {24'h00_0000, s_q.cmd};
        `OFS_STATUS: s_d.rdata = {29'h0000_0000, busy, 1'b0, s_q.reject}; // RULE19
        `OFS_ADDR_LO: s_d.rdata = {24'h00_0000, s_q.addr_lo};
        `OFS_ADDR_HI: s_d.rdata = {24'h00_0000, s_q.addr_hi};
        `OFS_DATA: s_d.rdata = {24'h00_0000, s_q.data};
        `OFS_CONFIG: s_d.rdata = {25'h000_0000, s_q.iap_en, 4'h0, s_q.cfg1, s_q.boot_bank_select};
        `OFS_NVBITS: s_d.rdata = {25'h000_0000, s_q.iap_dis, s_q.clk_dbl, s_q.sc, s_q.sec};
        default: s_d.rdata = `RST_WORD;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '{st: iap_flash_pkg::ST_IDLE, op: iap_flash_pkg::OP_NONE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s_q.ack;
  assign avs_readdata_o = s_q.rdata;
  assign ext_irq_one_o = s_q.irq_out; // RULE21
  assign clk_double_o = s_q.clk_dbl; // RULE18
  assign boot_bank_select_o = s_q.boot_bank_select; // RULE16
  assign code_rd_fail_o = code_rd_req_i && busy && |(code_rd_block_i & s_q.blk); // RULE20

  // Request to the flash array
  always_comb begin
    flash_req_o.valid = busy;
    flash_req_o.op = s_q.op;
    flash_req_o.block_mask = s_q.blk;
    flash_req_o.addr = {s_q.addr_hi, s_q.addr_lo}; // RULE7 RULE8
    flash_req_o.wdata = s_q.data; // RULE8
  end

endmodule : iap_flash_command_sequencer
`default_nettype wire

/* tb/iap_flash_properties.sv */
// Port-level checks of the flash command sequencer
`default_nettype none
`timescale 1ns/10ps
module iap_flash_props (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  // Pins and core side
  input wire logic external_access_pin_i,
  input wire logic ext_irq_one_pin_i,
  input wire logic code_rd_req_i,
  input wire logic [1:0] code_rd_block_i,
  input wire logic code_rd_fail_o,
  input wire logic ext_irq_one_o,
  input wire logic clk_double_o,
  input wire logic boot_bank_select_o,
  // Array link
  input wire iap_flash_pkg::flash_req_s flash_req_o,
  input wire logic flash_done_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [1:0] up_q;
  logic vfy;
  logic run_end;
  logic cmd_wr;
  // Cycles since reset release, saturating
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  // Decodes of the array link and the bus
  assign vfy = flash_req_o.op == iap_flash_pkg::OP_BYTE_VERIFY;
  assign run_end = flash_req_o.valid && !vfy && flash_done_i;
  assign cmd_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h00;
  sequence s_cmd_taken; $past(cmd_wr) && avs_byteenable_i[0]; endsequence
  sequence s_busy_then_idle; flash_req_o.valid ##1 !flash_req_o.valid; endsequence
  property p_start; $rose(flash_req_o.valid) |-> s_cmd_taken; endproperty
  property p_wait; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  property p_verify; $rose(flash_req_o.valid) && vfy |-> s_busy_then_idle; endproperty
  property p_run_end; run_end |=> !flash_req_o.valid; endproperty
  property p_hold; flash_req_o.valid && !vfy && !flash_done_i |=> flash_req_o.valid; endproperty
  property p_stable; flash_req_o.valid && $past(flash_req_o.valid) |-> $stable(flash_req_o);
  endproperty
  property p_fail; code_rd_fail_o == (code_rd_req_i && flash_req_o.valid
    && (code_rd_block_i & flash_req_o.block_mask) != 2'h0); endproperty
  property p_irq; $rose(ext_irq_one_o) |-> $past(run_end) || $past(ext_irq_one_pin_i, 2)
    || $past(ext_irq_one_pin_i, 3) || $past(ext_irq_one_pin_i, 4); endproperty
  property p_dbl; $rose(clk_double_o)
    |-> $past(run_end) && $past(flash_req_o.op) == iap_flash_pkg::OP_CLK_DOUBLE; endproperty
  property p_bank; up_q == 2'h3 && $past(up_q) == 2'h3 |-> $stable(boot_bank_select_o);
  endproperty
  property p_chip; $rose(flash_req_o.valid) && flash_req_o.op == iap_flash_pkg::OP_CHIP_ERASE
    |-> !$past(external_access_pin_i, 4); endproperty
  a_start: assert property (p_start) else $error("operation began without a command write");
  a_wait: assert property (p_wait) else $error("bus wait longer than one cycle");
  a_verify: assert property (p_verify) else $error("read-back busy not one cycle");
  a_run_end: assert property (p_run_end) else $error("busy after array done");
  a_hold: assert property (p_hold) else $error("busy dropped before array done");
  a_stable: assert property (p_stable) else $error("array request changed while busy");
  a_fail: assert property (p_fail) else $error("code read fail flag wrong");
  a_irq: assert property (p_irq) else $error("interrupt without completion or pin");
  a_dbl: assert property (p_dbl) else $error("clock double without its command");
  a_bank: assert property (p_bank) else $error("bank select moved after start-up");
  a_chip: assert property (p_chip) else $error("whole erase with access pin high");
endmodule : iap_flash_props
bind iap_flash_command_sequencer iap_flash_props i_iap_flash_props (.clk_i, .rst_b_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i, .avs_waitrequest_o,
  .external_access_pin_i, .ext_irq_one_pin_i, .code_rd_req_i, .code_rd_block_i,
  .code_rd_fail_o, .ext_irq_one_o, .clk_double_o, .boot_bank_select_o, .flash_req_o,
  .flash_done_i);
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench of the flash command sequencer
`default_nettype none
`timescale 1ns/10ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic external_access_pin_i = 1'b0;
  logic programming_disable_pin_i = 1'b1;
  logic ext_irq_one_pin_i = 1'b0;
  iap_flash_pkg::fetch_src_e fetch_src_i = iap_flash_pkg::SRC_EXTERNAL;
  logic code_rd_req_i = 1'b0;
  logic [1:0] code_rd_block_i = 2'h0;
  logic code_rd_fail_o;
  logic ext_irq_one_o;
  logic clk_double_o;
  logic boot_bank_select_o;
  logic [2:0] nvm_security_i = 3'h0;
  logic [1:0] nvm_boot_cfg_i = 2'h0;
  iap_flash_pkg::flash_req_s flash_req_o;
  logic flash_done_i = 1'b0;
  logic [7:0] flash_rdata_i = 8'h00;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [4:0] dly = 5'h0c;
  int irq_n = 0;
  int err_total = 0;
  int tests_run = 0;

  iap_flash_command_sequencer i_iap_flash_command_sequencer (.clk_i, .rst_b_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .external_access_pin_i, .programming_disable_pin_i, .ext_irq_one_pin_i,
    .fetch_src_i, .code_rd_req_i, .code_rd_block_i, .code_rd_fail_o, .ext_irq_one_o,
    .clk_double_o, .boot_bank_select_o, .nvm_security_i, .nvm_boot_cfg_i, .flash_req_o,
    .flash_done_i, .flash_rdata_i);

  // Free-running clock
  always #2 clk_i = ~clk_i;

  task automatic report_and_stop;
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    tests_run++;
    if ((got & m) !== (exp & m)) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got & m, exp & m);
    end
  endtask : cmp

  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'h00_0000, d};
    avs_byteenable_i <= 4'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (n == 50) begin
      err_total++;
      report_and_stop();
    end
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 8'h00);
  endtask : rd_chk

  task automatic wait_idle;
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_i);
      if (flash_req_o.valid === 1'b0) break;
    end
    if (n == 100) begin
      err_total++;
      report_and_stop();
    end
  endtask : wait_idle

  // Load mailbox, issue a command, check the request and its end
  task automatic do_cmd(input logic [7:0] c, input logic [7:0] d, input logic [7:0] ah,
    input iap_flash_pkg::flash_op_e op, input logic [1:0] mk, input logic ok);
    logic [7:0] al;
    al = 8'($urandom);
    bus(1'b1, 8'h10, d);
    bus(1'b1, 8'h0c, ah);
    bus(1'b1, 8'h08, al);
    bus(1'b1, 8'h00, c);
    #1;
    cmp(32'(flash_req_o.valid), 32'(ok), 32'h0000_0001);
    cmp(32'(code_rd_fail_o), 32'(ok && code_rd_req_i && (code_rd_block_i & mk) != 2'h0),
      32'h0000_0001);
    if (!ok) rd_chk(8'h04, 32'h0000_0001, 32'h0000_0005);
    else begin
      cmp(32'({flash_req_o.op, flash_req_o.block_mask, flash_req_o.addr, flash_req_o.wdata}),
        32'({op, mk, ah, al, d}), (op >= iap_flash_pkg::OP_PROG_SB1) ? 32'h3cff_ffff
        : 32'h3fff_ffff);
      if (op != iap_flash_pkg::OP_BYTE_VERIFY) begin
        rd_chk(8'h04, 32'h0000_0004, 32'h0000_0004);
        bus(1'b1, 8'h00, 8'h01);
        rd_chk(8'h00, 32'(c), 32'h0000_00ff);
      end
      wait_idle();
      rd_chk(8'h04, 32'h0000_0000, 32'h0000_0005);
    end
  endtask : do_cmd

  // Read results against the oldest note
  always @(posedge clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
      cmp(avs_readdata_o, exp_q.pop_front(), msk_q.pop_front());
  end

  // Array answers after a random delay; code-read probes; interrupt count
  always @(posedge clk_i) begin
    code_rd_req_i <= 1'($urandom);
    code_rd_block_i <= 2'($urandom);
    if (ext_irq_one_o === 1'b1) irq_n <= irq_n + 1;
    if (flash_req_o.valid === 1'b1 && flash_req_o.op !== iap_flash_pkg::OP_BYTE_VERIFY
      && !flash_done_i) begin
      if (dly == 5'h00) begin
        flash_done_i <= 1'b1;
        dly <= 5'($urandom_range(16, 12));
      end else dly <= dly - 5'h01;
    end else flash_done_i <= 1'b0;
  end

  // Main sequence
  initial begin
    void'($urandom(32'ha691));
    flash_rdata_i = 8'($urandom);
    nvm_boot_cfg_i = 2'($urandom);
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    cmp(32'(boot_bank_select_o), 32'(nvm_boot_cfg_i[0]), 32'h0000_0001);
    rd_chk(8'h18, 32'({nvm_boot_cfg_i, 3'h0}), 32'h0000_007f);
    rd_chk(8'h40, 32'h0000_0000, 32'hffff_ffff);
    do_cmd(8'h0e, 8'h3c, 8'h01, iap_flash_pkg::OP_BYTE_PROG, 2'h1, 1'b0);
    bus(1'b1, 8'h14, 8'h40);
    do_cmd(8'h0d, 8'h55, 8'h00, iap_flash_pkg::OP_BLOCK_ERASE, 2'h1, 1'b1);
    do_cmd(8'h0d, 8'h55, 8'he0, iap_flash_pkg::OP_BLOCK_ERASE, 2'h2, 1'b1);
    fetch_src_i <= iap_flash_pkg::SRC_BLOCK0;
    do_cmd(8'h0b, 8'h00, 8'h12, iap_flash_pkg::OP_SECTOR_ERASE, 2'h2, 1'b1);
    fetch_src_i <= iap_flash_pkg::SRC_EXTERNAL;
    do_cmd(8'h8e, 8'($urandom), 8'h34, iap_flash_pkg::OP_BYTE_PROG, 2'h1, 1'b1);
    cmp(32'(irq_n), 32'h0000_0001, 32'hffff_ffff);
    do_cmd(8'h8c, 8'h00, 8'he5, iap_flash_pkg::OP_BYTE_VERIFY, 2'h2, 1'b1);
    rd_chk(8'h10, 32'(flash_rdata_i), 32'h0000_00ff);
    cmp(32'(irq_n), 32'h0000_0001, 32'hffff_ffff);
    do_cmd(8'h09, 8'haa, 8'h5a, iap_flash_pkg::OP_PROG_SC0, 2'h0, 1'b1);
    do_cmd(8'h09, 8'haa, 8'haa, iap_flash_pkg::OP_PROG_SC1, 2'h0, 1'b1);
    do_cmd(8'h08, 8'haa, 8'h55, iap_flash_pkg::OP_CLK_DOUBLE, 2'h0, 1'b1);
    cmp(32'(clk_double_o), 32'h0000_0001, 32'h0000_0001);
    cmp(32'(boot_bank_select_o), 32'(nvm_boot_cfg_i[0]), 32'h0000_0001);
    rd_chk(8'h14, 32'({nvm_boot_cfg_i[1], 1'b0}), 32'h0000_0002);
    rd_chk(8'h18, 32'h0000_0038, 32'h0000_003f);
    do_cmd(8'h0f, 8'haa, 8'h00, iap_flash_pkg::OP_PROG_SB1, 2'h0, 1'b1);
    do_cmd(8'h0e, 8'h5a, 8'h01, iap_flash_pkg::OP_BYTE_PROG, 2'h1, 1'b0);
    external_access_pin_i <= 1'b1;
    do_cmd(8'h01, 8'h55, 8'h00, iap_flash_pkg::OP_CHIP_ERASE, 2'h3, 1'b0);
    external_access_pin_i <= 1'b0;
    do_cmd(8'h01, 8'h55, 8'h00, iap_flash_pkg::OP_CHIP_ERASE, 2'h3, 1'b1);
    rd_chk(8'h18, 32'h0000_0000, 32'h0000_0007);
    do_cmd(8'h0f, 8'haa, 8'h00, iap_flash_pkg::OP_PROG_SB1, 2'h0, 1'b1);
    do_cmd(8'h03, 8'haa, 8'h00, iap_flash_pkg::OP_PROG_SB2, 2'h0, 1'b1);
    do_cmd(8'h05, 8'haa, 8'h00, iap_flash_pkg::OP_PROG_SB3, 2'h0, 1'b1);
    rd_chk(8'h18, 32'h0000_0007, 32'h0000_0007);
    // Second reset with the disable pin low: commands stay refused
    programming_disable_pin_i <= 1'b0;
    rst_b_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd_chk(8'h18, 32'h0000_0040, 32'h0000_0040);
    bus(1'b1, 8'h14, 8'h40);
    do_cmd(8'h0d, 8'h55, 8'h00, iap_flash_pkg::OP_BLOCK_ERASE, 2'h1, 1'b0);
    do_cmd(8'h01, 8'h55, 8'h00, iap_flash_pkg::OP_CHIP_ERASE, 2'h3, 1'b0);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
